// file: include/dac_update_if.sv
// Interface carrying held codes and update strobes to the code stage
interface dac_update_if;
  logic [1:0]  load;
  logic [11:0] code0;
  logic [11:0] code1;
  modport source (output load, output code0, output code1);
  modport sink   (input load, input code0, input code1);
endinterface : dac_update_if

// file: include/dual_dac_pkg.sv
// Constants shared by the dual converter register control block
package dual_dac_pkg;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] ADDR_CHAN0_DATA_LOW    = 8'hf9;
  localparam logic [7:0] ADDR_CHAN0_DATA_HIGH   = 8'hfa;
  localparam logic [7:0] ADDR_CHAN1_DATA_LOW    = 8'hfb;
  localparam logic [7:0] ADDR_CHAN1_DATA_HIGH   = 8'hfc;
  localparam logic [7:0] ADDR_CONVERTER_CONTROL = 8'hfd;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] CONTROL_RESET = 8'h04;
  localparam logic [7:0] DATA_RESET    = 8'h00;

  // ****************************************
  // Control field positions
  // ****************************************
  localparam int BIT_MODE_8BIT   = 7;
  localparam int BIT_CHAN1_RANGE = 6;
  localparam int BIT_CHAN0_RANGE = 5;
  localparam int BIT_CHAN1_CLEAR = 4;
  localparam int BIT_CHAN0_CLEAR = 3;
  localparam int BIT_SYNC        = 2;
  localparam int BIT_CHAN1_POWER = 1;
  localparam int BIT_CHAN0_POWER = 0;

  localparam int NUM_CHAN   = 2;
  localparam int CODE_WIDTH = 12;
endpackage : dual_dac_pkg

// file: rtl/dac_code_stage.sv
// Applied converter codes per channel, loaded on update strobes
module dac_code_stage (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Update request
  dac_update_if.sink       upd,
  // Applied codes
  output logic [11:0]      applied0,
  output logic [11:0]      applied1
);
  // ****************************************
  // Code registers
  // ****************************************
  // Load channel zero on its strobe only
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      applied0 <= 12'h000;
    end else if (upd.load[0]) begin
      applied0 <= upd.code0;
    end
  end

  // Load channel one on its strobe only
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      applied1 <= 12'h000;
    end else if (upd.load[1]) begin
      applied1 <= upd.code1;
    end
  end
endmodule : dac_code_stage

// file: rtl/dual_dac_register_control.sv
// Register side control of two 12-bit voltage output converters
// Behaviour
// R1: Mode bit one selects 8-bit, zero 12-bit
// R2: Bit six selects channel one range
// R3: Bit five selects channel zero range
// R4: Bit four zero forces channel one to zero
// R5: Bit three zero forces channel zero to zero
// R6: Sync one: low byte write updates output
// R7: Sync zero holds; setting sync updates both
// R8: Bit one powers channel one
// R9: Bit zero powers channel zero
// R10: Control resets to 04H
// R11: Disabled channel output is high impedance
// R12: Data registers reset to 00H
// R13: 12-bit code is right justified
// R14: Software writes high byte before low
// R15: High byte write alone changes no output
module dual_dac_register_control (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Special function register port
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_write,
  input  wire logic [7:0]  sfr_wdata,
  input  wire logic        sfr_read,
  output logic      [7:0]  sfr_rdata,
  output logic             sfr_hit,
  // Channel zero analog controls
  output logic      [11:0] chan0_code,
  output logic             chan0_range_sel,
  output logic             chan0_drive_en,
  // Channel one analog controls
  output logic      [11:0] chan1_code,
  output logic             chan1_range_sel,
  output logic             chan1_drive_en
);
  // ****************************************
  // Registers
  // ****************************************
  logic [7:0]  converter_control;
  logic [7:0]  chan0_data_low;
  logic [7:0]  chan0_data_high;
  logic [7:0]  chan1_data_low;
  logic [7:0]  chan1_data_high;
  logic [11:0] applied0;
  logic [11:0] applied1;
  logic        wr_ctl;
  logic        wr_low0;
  logic        wr_low1;
  logic        wr_high0;
  logic        wr_high1;
  logic        rd_mapped;
  logic        sync_rise;
  logic        mode_8bit;
  logic [7:0]  next_low0;
  logic [7:0]  next_low1;
  logic [7:0]  next_high0;
  logic [7:0]  next_high1;

  dac_update_if upd ();

  // Write decode
  assign wr_ctl  = sfr_write && (sfr_addr == dual_dac_pkg::ADDR_CONVERTER_CONTROL);
  assign wr_low0 = sfr_write && (sfr_addr == dual_dac_pkg::ADDR_CHAN0_DATA_LOW);
  assign wr_low1 = sfr_write && (sfr_addr == dual_dac_pkg::ADDR_CHAN1_DATA_LOW);
  assign wr_high0 = sfr_write && (sfr_addr == dual_dac_pkg::ADDR_CHAN0_DATA_HIGH);
  assign wr_high1 = sfr_write && (sfr_addr == dual_dac_pkg::ADDR_CHAN1_DATA_HIGH);
  // Read of one of the five mapped places
  assign rd_mapped = sfr_read && (sfr_addr >= dual_dac_pkg::ADDR_CHAN0_DATA_LOW)
                     && (sfr_addr <= dual_dac_pkg::ADDR_CONVERTER_CONTROL);
  // Sync written to one from zero releases held data
  assign sync_rise = wr_ctl && sfr_wdata[dual_dac_pkg::BIT_SYNC]
                     && !converter_control[dual_dac_pkg::BIT_SYNC]; // see R7
  assign mode_8bit = converter_control[dual_dac_pkg::BIT_MODE_8BIT]; // see R1

  // ****************************************
  // Control register
  // ****************************************
  // Shared control, 04H after reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      converter_control <= dual_dac_pkg::CONTROL_RESET; // see R10
    end else if (wr_ctl) begin
      converter_control <= sfr_wdata;
    end
  end

  // ****************************************
  // Data registers
  // ****************************************
  // Next values of the four data bytes
  always_comb begin
    next_low0  = chan0_data_low;
    next_low1  = chan1_data_low;
    next_high0 = chan0_data_high;
    next_high1 = chan1_data_high;
    if (wr_low0) begin
      next_low0 = sfr_wdata;
    end
    if (wr_low1) begin
      next_low1 = sfr_wdata;
    end
    if (wr_high0) begin
      next_high0 = sfr_wdata; // see R15
    end
    if (wr_high1) begin
      next_high1 = sfr_wdata; // see R15
    end
  end

  // Data bytes, all 00H after reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      chan0_data_low  <= dual_dac_pkg::DATA_RESET; // see R12
      chan0_data_high <= dual_dac_pkg::DATA_RESET;
      chan1_data_low  <= dual_dac_pkg::DATA_RESET;
      chan1_data_high <= dual_dac_pkg::DATA_RESET;
    end else begin
      chan0_data_low  <= next_low0;
      chan0_data_high <= next_high0;
      chan1_data_low  <= next_low1;
      chan1_data_high <= next_high1;
    end
  end

  // ****************************************
  // Update requests
  // ****************************************
  // Codes from next data so a low write applies in the same cycle
  always_comb begin
    if (mode_8bit) begin
      upd.code0 = {4'h0, next_low0}; // see R1
      upd.code1 = {4'h0, next_low1};
    end else begin
      upd.code0 = {next_high0[3:0], next_low0}; // see R13
      upd.code1 = {next_high1[3:0], next_low1};
    end
  end

  // Immediate low byte update or joint update on sync set
  always_comb begin
    upd.load[0] = (wr_low0 && converter_control[dual_dac_pkg::BIT_SYNC] && !wr_ctl)
                  || sync_rise; // see R6, R7
    upd.load[1] = (wr_low1 && converter_control[dual_dac_pkg::BIT_SYNC] && !wr_ctl)
                  || sync_rise; // see R6, R7
  end

  dac_code_stage u_code (
    .clk      (clk),
    .resetn   (resetn),
    .upd      (upd.sink),
    .applied0 (applied0),
    .applied1 (applied1)
  );

  // ****************************************
  // Analog controls
  // ****************************************
  // Applied code, forced to zero while clear is low
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      chan0_code <= 12'h000;
      chan1_code <= 12'h000;
    end else begin
      chan0_code <= converter_control[dual_dac_pkg::BIT_CHAN0_CLEAR]
                    ? applied0 : 12'h000; // see R5
      chan1_code <= converter_control[dual_dac_pkg::BIT_CHAN1_CLEAR]
                    ? applied1 : 12'h000; // see R4
    end
  end

  // Range selects follow the control fields
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      chan0_range_sel <= 1'b0;
      chan1_range_sel <= 1'b0;
    end else begin
      chan0_range_sel <= converter_control[dual_dac_pkg::BIT_CHAN0_RANGE]; // see R3
      chan1_range_sel <= converter_control[dual_dac_pkg::BIT_CHAN1_RANGE]; // see R2
    end
  end

  // Drive enables, output floats while powered off
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      chan0_drive_en <= 1'b0;
      chan1_drive_en <= 1'b0;
    end else begin
      chan0_drive_en <= converter_control[dual_dac_pkg::BIT_CHAN0_POWER]; // see R9, R11
      chan1_drive_en <= converter_control[dual_dac_pkg::BIT_CHAN1_POWER]; // see R8, R11
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  // Registered read data, zero outside a read
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sfr_rdata <= 8'h00;
    end else if (!sfr_read) begin
      sfr_rdata <= 8'h00;
    end else begin
      unique case (sfr_addr)
        dual_dac_pkg::ADDR_CHAN0_DATA_LOW:    sfr_rdata <= chan0_data_low;
        dual_dac_pkg::ADDR_CHAN0_DATA_HIGH:   sfr_rdata <= chan0_data_high;
        dual_dac_pkg::ADDR_CHAN1_DATA_LOW:    sfr_rdata <= chan1_data_low;
        dual_dac_pkg::ADDR_CHAN1_DATA_HIGH:   sfr_rdata <= chan1_data_high;
        dual_dac_pkg::ADDR_CONVERTER_CONTROL: sfr_rdata <= converter_control;
        default:                              sfr_rdata <= 8'h00;
      endcase
    end
  end

  // Hit flag for reads of mapped places
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sfr_hit <= 1'b0;
    end else begin
      sfr_hit <= rd_mapped;
    end
  end
endmodule : dual_dac_register_control

// file: verification/dual_dac_checker.sv
// Port assertions for the dual converter register control block
module dual_dac_checker (
  // Clock, reset and register port
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic [7:0]  sfr_addr,
  input wire logic        sfr_write,
  input wire logic [7:0]  sfr_wdata,
  input wire logic        sfr_read,
  input wire logic [7:0]  sfr_rdata,
  input wire logic        sfr_hit,
  // Channel controls
  input wire logic [11:0] chan0_code,
  input wire logic        chan0_range_sel,
  input wire logic        chan0_drive_en,
  input wire logic [11:0] chan1_code,
  input wire logic        chan1_range_sel,
  input wire logic        chan1_drive_en
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Control write, mapped and unmapped read requests
  sequence s_ctl;
    sfr_write && sfr_addr == dual_dac_pkg::ADDR_CONVERTER_CONTROL;
  endsequence
  sequence s_map_rd;
    sfr_read && sfr_addr inside {[8'hf9:8'hfd]};
  endsequence
  sequence s_unmap_rd;
    sfr_read && !(sfr_addr inside {[8'hf9:8'hfd]});
  endsequence
  // Control fields show two samples after the write; a channel zero high byte write leaves chan0_code stable
  property p_chan0_range_sel; s_ctl |-> ##2 chan0_range_sel == $past(sfr_wdata[5], 2); endproperty
  property p_chan1_range_sel; s_ctl |-> ##2 chan1_range_sel == $past(sfr_wdata[6], 2); endproperty
  property p_pwr0; s_ctl |-> ##2 chan0_drive_en == $past(sfr_wdata[0], 2); endproperty
  property p_pwr1; s_ctl |-> ##2 chan1_drive_en == $past(sfr_wdata[1], 2); endproperty
  property p_chan0_clear_n; s_ctl ##0 !sfr_wdata[3] |-> ##2 chan0_code == 12'h000; endproperty
  property p_chan1_clear_n; s_ctl ##0 !sfr_wdata[4] |-> ##2 chan1_code == 12'h000; endproperty
  property p_hold; sfr_write && sfr_addr == 8'hfa |-> ##2 $stable(chan0_code); endproperty
  // Read answers
  property p_hit; s_map_rd |=> sfr_hit; endproperty
  property p_miss; s_unmap_rd |=> !sfr_hit && sfr_rdata == 8'h00; endproperty
  a_chan0_range_sel: assert property (p_chan0_range_sel) else $error("range0 wrong");
  a_chan1_range_sel: assert property (p_chan1_range_sel) else $error("range1 wrong");
  a_pwr0: assert property (p_pwr0) else $error("drive0 wrong");
  a_pwr1: assert property (p_pwr1) else $error("drive1 wrong");
  a_chan0_clear_n: assert property (p_chan0_clear_n) else $error("clear0 ignored");
  a_chan1_clear_n: assert property (p_chan1_clear_n) else $error("clear1 ignored");
  a_hold: assert property (p_hold) else $error("high byte moved code");
  a_hit: assert property (p_hit) else $error("no hit");
  a_miss: assert property (p_miss) else $error("unmapped read answered");
endmodule : dual_dac_checker

bind dual_dac_register_control dual_dac_checker u_dual_dac_checker (.clk, .resetn, .sfr_addr,
  .sfr_write, .sfr_wdata, .sfr_read, .sfr_rdata, .sfr_hit, .chan0_code, .chan0_range_sel,
  .chan0_drive_en, .chan1_code, .chan1_range_sel, .chan1_drive_en);

// file: verification/dual_dac_register_control_tb.sv
// Self-checking bench for the dual converter register control block
module dual_dac_register_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        sfr_write = 1'b0;
  logic        sfr_read = 1'b0;
  logic [7:0]  sfr_addr = 8'h00;
  logic [7:0]  sfr_wdata = 8'h00;
  logic [7:0]  sfr_rdata, hi, lo, a;
  logic        sfr_hit, chan0_range_sel, chan0_drive_en, chan1_range_sel, chan1_drive_en, ch;
  logic [11:0] chan0_code, chan1_code;
  logic [11:0] exp_c [2] = '{12'h000, 12'h000};
  int          errors = 0;
  int          num_checks = 0;

  dual_dac_register_control u_dual_dac_register_control (.clk, .resetn, .sfr_addr, .sfr_write,
    .sfr_wdata, .sfr_read, .sfr_rdata, .sfr_hit, .chan0_code, .chan0_range_sel,
    .chan0_drive_en, .chan1_code, .chan1_range_sel, .chan1_drive_en);

  // Clock
  always #2 clk = ~clk;

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // One write, then wait until its effect shows
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge clk);
    sfr_addr  <= ad;
    sfr_wdata <= d;
    sfr_write <= 1'b1;
    @(posedge clk);
    sfr_write <= 1'b0;
    @(posedge clk);
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] ad, input logic [7:0] exp);
    @(posedge clk);
    sfr_addr <= ad;
    sfr_read <= 1'b1;
    @(posedge clk);
    sfr_read <= 1'b0;
    #1;
    chk({4'h0, sfr_rdata}, {4'h0, exp});
    chk({11'h000, sfr_hit}, {11'h000, ad inside {[8'hf9:8'hfd]}});
  endtask : rd

  // Expected code from the stored bytes
  function automatic logic [11:0] exp_code(input logic m8, input logic [7:0] h, l);
    return m8 ? {4'h0, l} : {h[3:0], l};
  endfunction : exp_code

  task automatic chk_codes;
    chk(chan0_code, exp_c[0]);
    chk(chan1_code, exp_c[1]);
  endtask : chk_codes

  task automatic end_of_test;
    if (errors == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_of_test

  // Watchdog
  initial begin
    #20us;
    errors++;
    end_of_test();
  end

  initial begin
    void'($urandom(32'h3940_c64a));
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    // Reset values, unmapped places, idle outputs
    for (int i = 8'hf8; i <= 8'hfe; i++) rd(i[7:0], i == 8'hfd ? 8'h04 : 8'h00);
    chk({10'h000, chan0_drive_en, chan1_drive_en}, 12'h000);
    wr(8'hfe, 8'hff);
    rd(8'hfd, 8'h04);
    // Range and power fields
    for (int k = 0; k < 4; k++) begin
      a = k == 0 ? 8'($urandom) : k == 1 ? 8'h3d : k == 2 ? 8'h5e : 8'h1f;
      wr(8'hfd, a);
      chk({8'h00, chan1_range_sel, chan0_range_sel, chan1_drive_en, chan0_drive_en},
          {8'h00, a[6], a[5], a[1], a[0]});
    end
    // Immediate updates, 12-bit then 8-bit mode
    for (int i = 0; i < 16; i++) begin
      if (i == 8) wr(8'hfd, 8'h9f);
      ch = 1'($urandom_range(1));
      hi = i == 0 ? 8'hff : 8'($urandom);
      lo = i == 0 ? 8'hff : 8'($urandom);
      wr(ch ? 8'hfc : 8'hfa, hi);
      chk_codes();
      wr(ch ? 8'hfb : 8'hf9, lo);
      exp_c[ch] = exp_code(i >= 8, hi, lo);
      chk_codes();
    end
    // Held writes, then joint update on sync
    wr(8'hfd, 8'h1b);
    wr(8'hfa, 8'h0c);
    wr(8'hf9, 8'h3e);
    wr(8'hfc, 8'h05);
    wr(8'hfb, 8'ha1);
    chk_codes();
    wr(8'hfd, 8'h1f);
    exp_c = '{12'hc3e, 12'h5a1};
    chk_codes();
    // Clear forces zero, release restores data
    wr(8'hfd, 8'h07);
    chk(chan0_code, 12'h000);
    chk(chan1_code, 12'h000);
    wr(8'hfd, 8'h1f);
    chk_codes();
    // Mid-run reset restores codes, drive enables and the five registers
    @(posedge clk);
    resetn <= 1'b0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    exp_c = '{12'h000, 12'h000};
    #1;
    chk_codes();
    chk({10'h000, chan0_drive_en, chan1_drive_en}, 12'h000);
    for (int i = 8'hf9; i <= 8'hfd; i++) rd(i[7:0], i == 8'hfd ? 8'h04 : 8'h00);
    end_of_test();
  end
endmodule : dual_dac_register_control_tb
